// file: include/fscr_consts.svh
`ifndef FSCR_CONSTS_SVH
`define FSCR_CONSTS_SVH

// Serial command opcodes
`define FSCR_CMD_RD_STATUS2 8'h07
`define FSCR_CMD_RD_ANY     8'h65
`define FSCR_CMD_WR_REGS    8'h01
`define FSCR_CMD_WR_ANY     8'h71

// Register addresses for the any-register commands
`define FSCR_ADDR_STATUS2   24'h000002
`define FSCR_ADDR_CONFIG1   24'h000003

// Reset values and field positions
`define FSCR_STATUS2_RESET  8'h00
`define FSCR_CONFIG1_RESET  8'h00
`define FSCR_BP_RESET       3'h0
`define FSCR_BP_ALL_SET     3'h7
`define FSCR_BP_LSB         2
`define FSCR_QUAD_BIT       1
`define FSCR_BPV_BIT        3

// Timing
`define FSCR_CLK_MHZ           20
`define FSCR_PERSIST_WRITE_NS  2000000
`define FSCR_VOL_WRITE_NS      50
`define FSCR_VOL_WRITE_CYC \
  ((`FSCR_VOL_WRITE_NS * `FSCR_CLK_MHZ + 999) / 1000)

`endif

// file: include/fscr_pkg.sv
`default_nettype none
package fscr_pkg;

  typedef struct packed {
    logic [4:0] reserved;
    logic       eraseResultFlag;
    logic       eraseSuspendedFlag;
    logic       programSuspendedFlag;
  } fscr_status_two_t;

  typedef struct packed {
    logic [1:0] reservedHi;
    logic       protectFromBottom;
    logic       reservedMid;
    logic       protectBitsVolatileSel;
    logic       paramSectorsTop;
    logic       wideIoDefault;
    logic       lockDefault;
  } fscr_config_one_t;

  typedef struct packed {
    logic eraseSuspended;
    logic programSuspended;
    logic eraseCheckStrobe;
    logic eraseCheckCompleted;
  } fscr_op_status_t;

  typedef struct packed {
    logic       protectFromBottom;
    logic       paramSectorsTop;
    logic [2:0] protectRangeBits;
    logic       wideIoDefault;
    logic       lockDefault;
  } fscr_protect_cfg_t;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } fscr_state_t;

endpackage
`default_nettype wire

// file: verilog/fscr_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fscr_consts.svh"

module fscr_status_config_regs #(
  parameter int PERSIST_WRITE_NS = `FSCR_PERSIST_WRITE_NS
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       spiSck,
  input  wire logic                       spiCsN,
  input  wire logic                       spiSi,
  output var  logic                       spiSo,
  output var  logic                       spiSoOeN,
  input  wire fscr_pkg::fscr_op_status_t  opStatus,
  input  wire logic                       uniformSectors,
  input  wire logic                       fourWireModeVol,
  input  wire logic                       fourWireModePersistProg,
  input  wire logic                       commandReset,
  output var  fscr_pkg::fscr_protect_cfg_t protectCfg,
  output var  logic                       writeBusy
);
  import fscr_pkg::*;

  localparam int PERSIST_WRITE_CYC =
    (PERSIST_WRITE_NS * `FSCR_CLK_MHZ + 999) / 1000;
  localparam int VOL_WRITE_CYC = `FSCR_VOL_WRITE_CYC;

  function automatic logic [7:0] regRead(
    input logic [23:0] addr,
    input logic [7:0]  statusTwo,
    input logic [7:0]  configOne
  );
    logic [7:0] val;
    val = 8'h00;
    if (addr == `FSCR_ADDR_STATUS2) begin
      val = statusTwo;
    end else if (addr == `FSCR_ADDR_CONFIG1) begin
      val = configOne;
    end
    return val;
  endfunction

  // Pin synchronisers: sck, cs_n, si kept together so they stay aligned
  logic [2:0]        pinMeta_r;
  logic [2:0]        pinSync_r;
  logic [2:0]        pinPrev_r;

  fscr_state_t       state_r;
  logic [2:0]        bitCnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        cmd_r;
  logic [23:0]       addr_r;
  logic [1:0]        addrCnt_r;
  logic [1:0]        dataCnt_r;
  logic [7:0]        wrFirst_r;
  logic [7:0]        wrSecond_r;
  logic [7:0]        outShift_r;
  logic              spiSo_r;
  logic              spiSoOeN_r;

  fscr_status_two_t  status_r;
  fscr_config_one_t  cfg_r;
  fscr_config_one_t  cfgNxt;
  logic [2:0]        bpPersist_r;
  logic [2:0]        bpVol_r;
  logic [31:0]       busyCnt_r;
  logic [31:0]       busyCntNxt;
  logic              writeBusy_r;
  fscr_protect_cfg_t protectCfg_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_r <= 3'h2;
      pinSync_r <= 3'h2;
      pinPrev_r <= 3'h2;
    end else begin
      pinMeta_r <= {spiSck, spiCsN, spiSi};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  wire       sckRise  = pinSync_r[2] & ~pinPrev_r[2];
  wire       sckFall  = ~pinSync_r[2] & pinPrev_r[2];
  wire       selected = ~pinSync_r[1];
  wire       csRise   = pinSync_r[1] & ~pinPrev_r[1];
  wire [7:0] inByte   = {shift_r[6:0], pinSync_r[0]};
  wire       byteDone = bitCnt_r == 3'h7;
  wire [23:0] addrFull = {addr_r[15:0], inByte};

  // Frame decoder; commands accepted on whole bytes only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_CMD;
      bitCnt_r   <= 3'h0;
      shift_r    <= 8'h00;
      cmd_r      <= 8'h00;
      addr_r     <= 24'h000000;
      addrCnt_r  <= 2'h0;
      dataCnt_r  <= 2'h0;
      wrFirst_r  <= 8'h00;
      wrSecond_r <= 8'h00;
      outShift_r <= 8'h00;
    end else if (!selected) begin
      state_r   <= ST_CMD;
      bitCnt_r  <= 3'h0;
      addrCnt_r <= 2'h0;
      dataCnt_r <= 2'h0;
    end else if (sckRise) begin
      bitCnt_r <= bitCnt_r + 3'h1;
      shift_r  <= inByte;
      if (byteDone) begin
        case (state_r)
          ST_CMD: begin
            cmd_r <= inByte;
            case (inByte)
              `FSCR_CMD_RD_STATUS2: begin
                outShift_r <= status_r;
                state_r    <= ST_RDATA;
              end
              `FSCR_CMD_RD_ANY,
              `FSCR_CMD_WR_ANY: begin
                state_r <= ST_ADDR;
              end
              `FSCR_CMD_WR_REGS: begin
                state_r <= ST_WDATA;
              end
              default: begin
                state_r <= ST_IGNORE;
              end
            endcase
          end
          ST_ADDR: begin
            addr_r    <= addrFull;
            addrCnt_r <= addrCnt_r + 2'h1;
            if (addrCnt_r == 2'h2) begin
              if (cmd_r == `FSCR_CMD_RD_ANY) begin
                outShift_r <= regRead(addrFull, status_r, cfg_r);
                state_r    <= ST_RDATA;
              end else begin
                state_r <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            dataCnt_r <= dataCnt_r + 2'h1;
            if (dataCnt_r == 2'h0) begin
              wrFirst_r <= inByte;
            end else begin
              wrSecond_r <= inByte;
              state_r    <= ST_IGNORE;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sckFall && state_r == ST_RDATA) begin
      // Rotate so a longer read repeats the same byte
      outShift_r <= {outShift_r[6:0], outShift_r[7]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spiSo_r    <= 1'b0;
      spiSoOeN_r <= 1'b1;
    end else begin
      if (sckFall && state_r == ST_RDATA) begin
        spiSo_r <= outShift_r[7];
      end
      spiSoOeN_r <= ~(selected && state_r == ST_RDATA);
    end
  end

  // Writes commit on deselect; ignored while an earlier write runs
  wire writeOk  = csRise & ~writeBusy_r & (bitCnt_r == 3'h0);
  wire isWrRegs = cmd_r == `FSCR_CMD_WR_REGS;
  wire isWrAny  = cmd_r == `FSCR_CMD_WR_ANY;
  wire bpWrite  = writeOk & isWrRegs & (dataCnt_r != 2'h0);
  wire wrRegsCfg = writeOk & isWrRegs & (dataCnt_r == 2'h2);
  // Status two is not in the writable map
  wire wrAnyCfg = writeOk & isWrAny & (dataCnt_r != 2'h0)
                  & (addr_r == `FSCR_ADDR_CONFIG1);
  wire cfgWrite = wrRegsCfg | wrAnyCfg;
  wire [7:0] cfgData = isWrRegs ? wrSecond_r : wrFirst_r;
  wire [2:0] bpData  = wrFirst_r[`FSCR_BP_LSB +: 3];
  wire bpvSetNow = cfgWrite & cfgData[`FSCR_BPV_BIT]
                   & ~cfg_r.protectBitsVolatileSel;
  wire persistWrite = cfgWrite
                      | (bpWrite & ~cfg_r.protectBitsVolatileSel);
  wire anyWrite = cfgWrite | bpWrite;
  wire quadClearRefused = fourWireModeVol & ~cfgData[`FSCR_QUAD_BIT];

  always_comb begin
    cfgNxt = cfg_r;
    if (cfgWrite) begin
      // One-time bits only ever go from 0 to 1, no error raised
      cfgNxt.protectFromBottom      = cfg_r.protectFromBottom
                                      | cfgData[5];
      cfgNxt.protectBitsVolatileSel = cfg_r.protectBitsVolatileSel
                                      | cfgData[3];
      cfgNxt.paramSectorsTop        = cfg_r.paramSectorsTop
                                      | cfgData[2];
      if (!quadClearRefused) begin
        cfgNxt.wideIoDefault = cfgData[`FSCR_QUAD_BIT];
      end
    end
    if (fourWireModePersistProg) begin
      cfgNxt.wideIoDefault = 1'b1;
    end
    cfgNxt.reservedHi  = 2'h0;
    cfgNxt.reservedMid = 1'b0;
    cfgNxt.lockDefault = cfg_r.lockDefault;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= `FSCR_CONFIG1_RESET;
    end else begin
      cfg_r <= cfgNxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bpPersist_r <= `FSCR_BP_RESET;
    end else if (bpvSetNow) begin
      bpPersist_r <= `FSCR_BP_ALL_SET;
    end else if (bpWrite && !cfg_r.protectBitsVolatileSel) begin
      bpPersist_r <= bpData;
    end
  end

  // Volatile copy: tracks persistent writes, alone in volatile mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bpVol_r <= `FSCR_BP_RESET;
    end else if (commandReset) begin
      bpVol_r <= cfg_r.protectBitsVolatileSel ? `FSCR_BP_ALL_SET
                                              : bpPersist_r;
    end else if (bpvSetNow) begin
      bpVol_r <= `FSCR_BP_ALL_SET;
    end else if (bpWrite) begin
      bpVol_r <= bpData;
    end
  end

  always_comb begin
    busyCntNxt = busyCnt_r;
    if (anyWrite) begin
      busyCntNxt = persistWrite ? 32'(PERSIST_WRITE_CYC)
                                : 32'(VOL_WRITE_CYC);
    end else if (busyCnt_r != 32'h0) begin
      busyCntNxt = busyCnt_r - 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_r   <= 32'h0;
      writeBusy_r <= 1'b0;
    end else begin
      busyCnt_r   <= busyCntNxt;
      writeBusy_r <= busyCntNxt != 32'h0;
    end
  end

  // Hardware-only status; no write path reaches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= `FSCR_STATUS2_RESET;
    end else begin
      status_r.reserved             <= 5'h00;
      status_r.eraseSuspendedFlag   <= opStatus.eraseSuspended;
      status_r.programSuspendedFlag <= opStatus.programSuspended;
      if (opStatus.eraseCheckStrobe) begin
        status_r.eraseResultFlag <= opStatus.eraseCheckCompleted;
      end
    end
  end

  wire [2:0] bpActive = cfg_r.protectBitsVolatileSel ? bpVol_r
                                                     : bpPersist_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      protectCfg_r <= '0;
    end else begin
      protectCfg_r.protectFromBottom <= cfg_r.protectFromBottom;
      protectCfg_r.paramSectorsTop   <= cfg_r.paramSectorsTop
                                        & ~uniformSectors;
      protectCfg_r.protectRangeBits  <= bpActive;
      protectCfg_r.wideIoDefault     <= cfg_r.wideIoDefault;
      protectCfg_r.lockDefault       <= cfg_r.lockDefault;
    end
  end

  assign spiSo      = spiSo_r;
  assign spiSoOeN   = spiSoOeN_r;
  assign protectCfg = protectCfg_r;
  assign writeBusy  = writeBusy_r;

endmodule
`default_nettype wire

// file: sim/fscr_status_config_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fscr_consts.svh"
module fscr_status_config_regs_chk #(
  parameter int PERSIST_WRITE_NS = `FSCR_PERSIST_WRITE_NS
) (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        spiCsN,
  input wire logic                        spiSoOeN,
  input wire logic                        uniformSectors,
  input wire logic                        fourWireModeVol,
  input wire logic                        fourWireModePersistProg,
  input wire fscr_pkg::fscr_protect_cfg_t protectCfg,
  input wire logic                        writeBusy
);
  import fscr_pkg::*;
  localparam int BusyMax = (PERSIST_WRITE_NS * `FSCR_CLK_MHZ + 999) / 1000;
  logic [15:0] busyCnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      busyCnt_r <= 16'h0;
    else
      busyCnt_r <= writeBusy ? busyCnt_r + 16'h1 : 16'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_OE_IDLE: assert property (spiCsN [*8] |-> spiSoOeN)
    else $error("output enabled outside a frame");
  AST_BUSY_AFTER_CS: assert property (
    $rose(writeBusy) |-> spiCsN && $past(spiCsN))
    else $error("write started inside a frame");
  AST_LOCK_ZERO: assert property (!protectCfg.lockDefault)
    else $error("lock default changed");
  AST_UNIFORM: assert property (
    uniformSectors [*3] |-> !protectCfg.paramSectorsTop)
    else $error("parameter location active on uniform array");
  AST_BOTTOM_STICKY: assert property (
    protectCfg.protectFromBottom |=> protectCfg.protectFromBottom)
    else $error("protection start bit cleared");
  AST_PARAM_STICKY: assert property (
    protectCfg.paramSectorsTop ##1 !uniformSectors [*3]
      |-> protectCfg.paramSectorsTop)
    else $error("parameter location bit cleared");
  AST_QUAD_HOLD: assert property (
    fourWireModeVol [*3] ##0 protectCfg.wideIoDefault
      |=> protectCfg.wideIoDefault)
    else $error("wide default cleared in four-wire mode");
  AST_QUAD_SET: assert property (
    fourWireModePersistProg |-> ##[1:3] protectCfg.wideIoDefault)
    else $error("wide default not set by four-wire programming");
  AST_BUSY_BOUND: assert property (busyCnt_r <= BusyMax)
    else $error("write busy too long");
  cover property ($rose(writeBusy));
  cover property ($fell(spiSoOeN));
  cover property (fourWireModeVol && protectCfg.wideIoDefault);
endmodule
bind fscr_status_config_regs fscr_status_config_regs_chk #(
  .PERSIST_WRITE_NS(PERSIST_WRITE_NS)
) uChk (
  .clk(clk), .rst(rst), .spiCsN(spiCsN), .spiSoOeN(spiSoOeN),
  .uniformSectors(uniformSectors), .fourWireModeVol(fourWireModeVol),
  .fourWireModePersistProg(fourWireModePersistProg),
  .protectCfg(protectCfg), .writeBusy(writeBusy)
);
`default_nettype wire

// file: sim/fscr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fscr_host_model (
  output var logic spiSck,
  output var logic spiCsN,
  output var logic spiSi,
  input wire logic spiSo,
  input wire logic spiSoOeN
);
  initial begin
    spiSck = 1'b0;
    spiCsN = 1'b1;
    spiSi  = 1'b0;
  end
  // Mode 0 frame, MSB first; clock idles low between frames
  task automatic frame(input logic [47:0] tx, input int nTx, nRx,
                       output logic [7:0] rx);
    rx = 8'h0;
    spiCsN = 1'b0;
    #200;
    for (int i = 0; i < nTx; i++) begin
      spiSi = tx[47-i];
      #200 spiSck = 1'b1;
      #200 spiSck = 1'b0;
    end
    spiSi = ~spiSi;
    for (int i = 0; i < nRx; i++) begin
      #200 spiSck = 1'b1;
      // Late sample: data lags the falling edge by a few system clocks
      #190 rx[7-i] = (spiSoOeN === 1'b0) ? spiSo : 1'bx;
      #10 spiSck = 1'b0;
    end
    #200 spiCsN = 1'b1;
    spiSi = ~spiSi;
    #400;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_flash_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fscr_consts.svh"
module tb_flash_status_config_regs;
  import fscr_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  wire logic         sck, csN, si, so, soOeN, writeBusy;
  fscr_op_status_t   op = 4'h0;
  logic              uni = 1'b0, fwVol = 1'b0, fwProg = 1'b0;
  logic              cmdRst = 1'b0;
  fscr_protect_cfg_t cfg;
  logic [7:0]        rv;
  int                numErrors = 0, totalChecks = 0, cycles = 0, busyCyc;
  always #25 clk = ~clk;
  fscr_host_model host (.spiSck(sck), .spiCsN(csN), .spiSi(si),
    .spiSo(so), .spiSoOeN(soOeN));
  fscr_status_config_regs #(.PERSIST_WRITE_NS(1000)) dut (
    .clk(clk), .rst(rst), .spiSck(sck), .spiCsN(csN), .spiSi(si),
    .spiSo(so), .spiSoOeN(soOeN), .opStatus(op), .uniformSectors(uni),
    .fourWireModeVol(fwVol), .fourWireModePersistProg(fwProg),
    .commandReset(cmdRst), .protectCfg(cfg), .writeBusy(writeBusy));
  task automatic check(input string nm, input logic [7:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (numErrors == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Runs beside the frame so the whole busy pulse is counted
  task automatic waitIdle();
    busyCyc = 0;
    for (int i = 0; i < 600; i++) begin
      @(negedge clk);
      if (writeBusy === 1'b1) busyCyc++;
      else if (busyCyc > 0) break;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic rdAny(input logic [23:0] a);
    host.frame({`FSCR_CMD_RD_ANY, a, 16'h0}, 32, 8, rv);
  endtask
  task automatic rd2();
    host.frame({`FSCR_CMD_RD_STATUS2, 40'h0}, 8, 8, rv);
  endtask
  task automatic wrAny(input logic [23:0] a, input logic [7:0] d);
    fork
      host.frame({`FSCR_CMD_WR_ANY, a, d, 8'h0}, 40, 0, rv);
      waitIdle();
    join
  endtask
  task automatic wrRegs(input logic [15:0] d, input int n);
    fork
      host.frame({`FSCR_CMD_WR_REGS, d, 24'h0}, 8 + n, 0, rv);
      waitIdle();
    join
  endtask
  task automatic tReset();
    rd2();
    check("status2", rv, 8'h00);
    rdAny(`FSCR_ADDR_CONFIG1);
    check("config1", rv, 8'h00);
    rdAny(24'h000010);
    check("unmapped", rv, 8'h00);
    check("protectCfg", {1'b0, cfg}, 8'h00);
  endtask
  task automatic tStatus();
    @(negedge clk) op = 4'hc;
    rd2();
    check("suspendBits", rv & 8'h03, 8'h03);
    @(negedge clk) op = 4'h3;
    @(negedge clk) op = 4'h0;
    rdAny(`FSCR_ADDR_STATUS2);
    check("eraseDone", rv, 8'h04);
    wrAny(`FSCR_ADDR_STATUS2, 8'hff);
    rd2();
    check("status2Ro", rv, 8'h04);
    @(negedge clk) op = 4'h2;
    @(negedge clk) op = 4'h0;
    rd2();
    check("eraseNotDone", rv, 8'h00);
  endtask
  task automatic tRegsWrite();
    wrRegs({8'h14, 8'hf7}, 16);
    check("persistBusy", 8'(busyCyc >= 19 && busyCyc <= 21), 8'h01);
    rdAny(`FSCR_ADDR_CONFIG1);
    check("config1", rv, 8'h26);
    check("protectCfg", {1'b0, cfg}, 8'h76);
  endtask
  task automatic tOtp();
    wrAny(`FSCR_ADDR_CONFIG1, 8'h00);
    rdAny(`FSCR_ADDR_CONFIG1);
    check("config1", rv, 8'h24);
    @(negedge clk) uni = 1'b1;
    repeat (4) @(negedge clk);
    check("uniform", {1'b0, cfg}, 8'h54);
    uni = 1'b0;
    repeat (4) @(negedge clk);
    check("hybrid", {1'b0, cfg}, 8'h74);
  endtask
  task automatic tQuad();
    @(negedge clk) fwProg = 1'b1;
    @(negedge clk) fwProg = 1'b0;
    repeat (4) @(negedge clk);
    rdAny(`FSCR_ADDR_CONFIG1);
    check("quadSet", rv, 8'h26);
    fwVol = 1'b1;
    wrAny(`FSCR_ADDR_CONFIG1, 8'h00);
    rdAny(`FSCR_ADDR_CONFIG1);
    check("quadKept", rv, 8'h26);
    fwVol = 1'b0;
  endtask
  task automatic tVol();
    wrAny(`FSCR_ADDR_CONFIG1, 8'h0a);
    check("rangeAll", {1'b0, cfg}, 8'h7e);
    wrRegs({8'h08, 8'h00}, 8);
    check("volBusy", 8'(busyCyc >= 1 && busyCyc <= 2), 8'h01);
    check("rangeVol", {1'b0, cfg}, 8'h6a);
    @(negedge clk) cmdRst = 1'b1;
    @(negedge clk) cmdRst = 1'b0;
    repeat (4) @(negedge clk);
    check("rangeReload", {1'b0, cfg}, 8'h7e);
  endtask
  // Unknown opcode and a cut write byte must both leave state alone
  task automatic tIgnore();
    fork
      host.frame({8'h5a, 8'h01, 8'h00, 24'h0}, 24, 0, rv);
      waitIdle();
    join
    check("unknownBusy", 8'(busyCyc), 8'h00);
    wrRegs({8'h00, 8'h00}, 15);
    check("partialBusy", 8'(busyCyc), 8'h00);
    check("rangeKept", {1'b0, cfg}, 8'h7e);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      numErrors++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    tReset();
    tStatus();
    tRegsWrite();
    tOtp();
    tQuad();
    tVol();
    tIgnore();
    conclude();
  end
endmodule
`default_nettype wire
